// >>> verilog/l2la_engine.v
// l2 learning, aging and destination hit update engine
`timescale 1ns/10ps
`include "l2la_map.vh"
module l2la_engine #(
  parameter NPORT = 24,
  parameter [4:0] CPU_PORT = 5'h00,
  parameter HQ_DEPTH = 8,
  parameter HQ_AW = 3,
  parameter [15:0] AGE_TICKS_RST = 16'h0100
) (
  // clock and reset
  input wire REF_CLK,
  input wire RST,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  // system ticks
  input wire [4:0] TICK,
  // source learning request
  input wire LRN_VALID,
  input wire [47:0] LRN_MAC,
  input wire [8:0] LRN_GID,
  input wire [7:0] LRN_HASH,
  input wire [4:0] LRN_PORT,
  input wire LRN_FROM_CPU,
  input wire LRN_TO_CPU_CODE,
  input wire LRN_FORCE_DEST,
  input wire LRN_ACL_SKIP,
  input wire LRN_DROP,
  input wire LRN_DROP_STP_LEARNING,
  // destination lookup
  input wire DA_VALID,
  input wire [47:0] DA_MAC,
  input wire [8:0] DA_GID,
  input wire [7:0] DA_HASH,
  output reg DA_HIT,
  output reg [10:0] DA_ADDR,
  output reg [4:0] DA_PORT,
  // writeback bus
  output reg WB_VALID,
  output reg [1:0] WB_KIND,
  output reg [10:0] WB_ADDR,
  output reg [56:0] WB_KEY,
  output reg [4:0] WB_PORT,
  output reg [2:0] WB_STATUS,
  // shadow valid copies
  output wire SHADOW_WE,
  output wire [10:0] SHADOW_ADDR,
  output wire SHADOW_SA_VALID,
  output wire SHADOW_DA_VALID
);

// ---------------------------------------------------------------
// storage
// ---------------------------------------------------------------
reg [2:0] st [0:`L2LA_NENT-1];
reg [`L2LA_KW-1:0] ekey [0:`L2LA_NENT-1];
reg [`L2LA_PW-1:0] eport [0:`L2LA_NENT-1];
reg [10:0] lcnt [0:NPORT-1];
reg [10:0] pmax [0:NPORT-1];
reg [NPORT-1:0] p_en, p_grp, p_stat, p_move;
reg [4:0] ctrl;
reg [2:0] tick_sel;
reg [15:0] age_cfg;
reg [56:0] ovf_key, cfl_key;
reg [4:0] ovf_port, cfl_port;
reg [10:0] hq [0:HQ_DEPTH-1];
reg [HQ_AW-1:0] hq_wp, hq_rp;
reg [HQ_AW:0] hq_cnt;
reg [3:0] rr;
integer i, k;

// {hit, address}: buckets first, the highest matching bucket wins
function [11:0] find;
  input [56:0] key;
  input [7:0] hash;
  integer j;
  reg [10:0] a;
  reg [11:0] c;
  begin
    find = 12'h000;
    c = 12'h000;
    for (j = 0; j < `L2LA_NBKT; j = j + 1) begin
      a = {1'b0, j[1:0], hash};
      if (st[a][`L2LA_S_VALID] && ekey[a] == key)
        find = {1'b1, a};
    end
    for (j = `L2LA_NCOLL - 1; j >= 0; j = j - 1) begin
      a = `L2LA_COLL_BASE | {7'h00, j[3:0]};
      if (st[a][`L2LA_S_VALID] && ekey[a] == key)
        c = {1'b1, a};
    end
    if (!find[11])
      find = c;
  end
endfunction

// ---------------------------------------------------------------
// learning request stage
// ---------------------------------------------------------------
reg s_v;
reg [56:0] s_key;
reg [7:0] s_hash;
reg [4:0] s_port;
wire grp_src = LRN_MAC[`L2LA_GRP_BIT] && LRN_MAC != `L2LA_BCAST;
wire lrn_ok = LRN_VALID && ctrl[`L2LA_C_LEARN] && p_en[LRN_PORT] &&
  !(ctrl[`L2LA_C_CPU] && LRN_PORT == CPU_PORT) && !LRN_FROM_CPU &&
  !LRN_TO_CPU_CODE && !LRN_FORCE_DEST && !LRN_ACL_SKIP &&
  !(LRN_DROP && !LRN_DROP_STP_LEARNING) &&
  !(grp_src && !p_grp[LRN_PORT]);

always @(posedge REF_CLK or posedge RST) begin
  if (RST) begin
    s_v <= 1'b0;
    s_key <= 57'h0;
    s_hash <= 8'h00;
    s_port <= 5'h00;
  end else begin
    s_v <= lrn_ok;
    s_key <= {LRN_GID, LRN_MAC};
    s_hash <= LRN_HASH;
    s_port <= LRN_PORT;
  end
end

// ---------------------------------------------------------------
// learning decision
// ---------------------------------------------------------------
reg [11:0] lk;
reg [2:0] o_st, cs, l_ws;
reg [4:0] o_port, l_wp, v_port;
reg [10:0] a, l_wa, fb, fc, lb, lc, sb, rc;
reg fb_ok, fc_ok, lb_ok, lc_ok, sb_ok, rc_ok, al_ok;
reg [10:0] al;
reg [3:0] ci;
reg l_we, l_inc, l_dec, ovf, cfl, full, rr_use;

always @* begin
  lk = find(s_key, s_hash);
  o_st = st[lk[10:0]];
  o_port = eport[lk[10:0]];
  full = lcnt[s_port] >= pmax[s_port];
  {fb_ok, fc_ok, lb_ok, lc_ok, sb_ok, rc_ok} = 6'h00;
  {fb, fc, lb, lc, sb, rc} = 66'h0;
  for (k = `L2LA_NBKT - 1; k >= 0; k = k - 1) begin
    a = {1'b0, k[1:0], s_hash};
    cs = st[a];
    if (!cs[`L2LA_S_VALID] && !cs[`L2LA_S_STAT]) begin
      fb_ok = 1'b1;
      fb = a;
    end
  end
  for (k = 0; k < `L2LA_NBKT; k = k + 1) begin
    a = {1'b0, k[1:0], s_hash};
    cs = st[a];
    if (!cs[`L2LA_S_STAT] && !cs[`L2LA_S_HIT]) begin
      lb_ok = 1'b1;
      lb = a;
    end
    if (!cs[`L2LA_S_STAT]) begin
      sb_ok = 1'b1;
      sb = a;
    end
  end
  for (k = `L2LA_NCOLL - 1; k >= 0; k = k - 1) begin
    a = `L2LA_COLL_BASE | {7'h00, k[3:0]};
    cs = st[a];
    if (!cs[`L2LA_S_VALID] && !cs[`L2LA_S_STAT]) begin
      fc_ok = 1'b1;
      fc = a;
    end
    if (!cs[`L2LA_S_STAT] && !cs[`L2LA_S_HIT]) begin
      lc_ok = 1'b1;
      lc = a;
    end
    ci = rr + k[3:0];
    a = `L2LA_COLL_BASE | {7'h00, ci};
    if (!st[a][`L2LA_S_STAT]) begin
      rc_ok = 1'b1;
      rc = a;
    end
  end
  // pick a slot; a victim that is still valid loses its port count
  al_ok = 1'b1;
  rr_use = 1'b0;
  if (fb_ok)
    al = fb;
  else if (fc_ok)
    al = fc;
  else if (ctrl[`L2LA_C_LRU] && lb_ok)
    al = lb;
  else if (ctrl[`L2LA_C_LRU] && lc_ok)
    al = lc;
  else if (ctrl[`L2LA_C_LRU] && sb_ok)
    al = sb;
  else begin
    al = rc;
    al_ok = rc_ok;
    rr_use = rc_ok;
  end
  v_port = eport[al];
  l_we = 1'b0;
  l_wa = lk[10:0];
  l_ws = o_st | 3'h4;
  l_wp = s_port;
  l_inc = 1'b0;
  l_dec = 1'b0;
  ovf = 1'b0;
  cfl = 1'b0;
  if (s_v && lk[11] && o_port == s_port) begin
    l_we = !o_st[`L2LA_S_HIT] && !o_st[`L2LA_S_STAT];
  end else if (s_v && lk[11]) begin
    if ((o_st[`L2LA_S_STAT] && !p_move[o_port]) || full) begin
      cfl = 1'b1;
    end else begin
      l_we = 1'b1;
      l_inc = 1'b1;
      l_dec = 1'b1;
      v_port = o_port;
    end
  end else if (s_v) begin
    if (full || !al_ok) begin
      ovf = 1'b1;
    end else begin
      l_we = 1'b1;
      l_wa = al;
      l_ws = {2'h2, 1'b1} | {1'b0, p_stat[s_port], 1'b0};
      l_inc = 1'b1;
      l_dec = st[al][`L2LA_S_VALID];
    end
  end
end

// ---------------------------------------------------------------
// aging timer and scan
// ---------------------------------------------------------------
reg [15:0] age_cnt, age_lim;
reg scan, ae_d;
reg [10:0] age_idx;
wire ae = ctrl[`L2LA_C_AGE];
wire sel_tick = (tick_sel < 3'h5) ? TICK[tick_sel] : 1'b0;
wire [2:0] a_st = st[age_idx];
wire a_need = scan && (a_st == `L2LA_ST_HV || a_st == `L2LA_ST_V);
wire [2:0] a_new = (a_st == `L2LA_ST_HV) ? `L2LA_ST_V : `L2LA_ST_NONE;
wire a_go = a_need && !l_we;

always @(posedge REF_CLK or posedge RST) begin
  if (RST) begin
    age_cnt <= 16'h0000;
    age_lim <= AGE_TICKS_RST;
    scan <= 1'b0;
    ae_d <= 1'b0;
    age_idx <= 11'h000;
  end else begin
    ae_d <= ae;
    if (!ae) begin
      scan <= 1'b0;
    end else if (!ae_d) begin
      age_lim <= age_cfg;
      age_cnt <= 16'h0000;
    end else if (!scan && sel_tick) begin
      if (age_cnt + 16'h0001 >= age_lim) begin
        scan <= 1'b1;
        age_idx <= 11'h000;
        age_cnt <= 16'h0000;
        age_lim <= age_cfg;
      end else begin
        age_cnt <= age_cnt + 16'h0001;
      end
    end else if (scan && (!a_need || a_go)) begin
      age_idx <= age_idx + 11'h001;
      if (age_idx == `L2LA_LAST)
        scan <= 1'b0;
    end
  end
end

// ---------------------------------------------------------------
// destination lookup and hit update queue
// ---------------------------------------------------------------
wire [11:0] dk = find({DA_GID, DA_MAC}, DA_HASH);
wire d_push = DA_VALID && dk[11] && ctrl[`L2LA_C_DHIT] &&
  !st[dk[10:0]][`L2LA_S_STAT];
wire hq_full = hq_cnt == HQ_DEPTH;
wire hq_pop = hq_cnt != 0 && !l_we && !a_need;
wire [10:0] h_adr = hq[hq_rp];
wire h_go = hq_pop && st[h_adr][`L2LA_S_VALID] && !st[h_adr][`L2LA_S_STAT];
wire hq_in = d_push && !hq_full;

always @(posedge REF_CLK or posedge RST) begin
  if (RST) begin
    DA_HIT <= 1'b0;
    DA_ADDR <= 11'h000;
    DA_PORT <= 5'h00;
    hq_wp <= {HQ_AW{1'b0}};
    hq_rp <= {HQ_AW{1'b0}};
    hq_cnt <= {(HQ_AW+1){1'b0}};
  end else begin
    DA_HIT <= DA_VALID && dk[11];
    DA_ADDR <= dk[10:0];
    DA_PORT <= eport[dk[10:0]];
    if (hq_in)
      hq_wp <= hq_wp + 1'b1;
    if (hq_pop)
      hq_rp <= hq_rp + 1'b1;
    if (hq_in && !hq_pop)
      hq_cnt <= hq_cnt + 1'b1;
    else if (hq_pop && !hq_in)
      hq_cnt <= hq_cnt - 1'b1;
  end
end

always @(posedge REF_CLK) begin
  if (hq_in)
    hq[hq_wp] <= dk[10:0];
  if (l_we) begin
    ekey[l_wa] <= s_key;
    eport[l_wa] <= l_wp;
  end
end

// ---------------------------------------------------------------
// writeback bus, status table and port counters
// ---------------------------------------------------------------
wire age_out = a_go && a_new == `L2LA_ST_NONE;
assign SHADOW_WE = WB_VALID;
assign SHADOW_ADDR = WB_ADDR;
assign SHADOW_SA_VALID = WB_STATUS[`L2LA_S_VALID];
assign SHADOW_DA_VALID = WB_STATUS[`L2LA_S_VALID];

always @(posedge REF_CLK or posedge RST) begin
  if (RST) begin
    for (i = 0; i < `L2LA_NENT; i = i + 1)
      st[i] <= `L2LA_ST_NONE;
    for (i = 0; i < NPORT; i = i + 1)
      lcnt[i] <= 11'h000;
    WB_VALID <= 1'b0;
    WB_KIND <= 2'h0;
    WB_ADDR <= 11'h000;
    WB_KEY <= 57'h0;
    WB_PORT <= 5'h00;
    WB_STATUS <= 3'h0;
    rr <= 4'h0;
  end else begin
    WB_VALID <= l_we || a_go || h_go;
    if (l_we) begin
      st[l_wa] <= l_ws;
      WB_KIND <= `L2LA_WB_LEARN;
      WB_ADDR <= l_wa;
      WB_KEY <= s_key;
      WB_PORT <= l_wp;
      WB_STATUS <= l_ws;
      if (rr_use && !lk[11])
        rr <= al[3:0] + 4'h1;
    end else if (a_go) begin
      st[age_idx] <= a_new;
      WB_KIND <= `L2LA_WB_AGE;
      WB_ADDR <= age_idx;
      WB_KEY <= ekey[age_idx];
      WB_PORT <= eport[age_idx];
      WB_STATUS <= a_new;
    end else if (h_go) begin
      st[h_adr] <= st[h_adr] | 3'h4;
      WB_KIND <= `L2LA_WB_HIT;
      WB_ADDR <= h_adr;
      WB_KEY <= ekey[h_adr];
      WB_PORT <= eport[h_adr];
      WB_STATUS <= st[h_adr] | 3'h4;
    end
    // one bus winner per cycle, so at most one raise and one drop
    for (i = 0; i < NPORT; i = i + 1) begin
      if (l_we && l_inc && s_port == i && !(l_dec && v_port == i))
        lcnt[i] <= lcnt[i] + 11'h001;
      else if (((l_we && l_dec && v_port == i) || (age_out && eport[age_idx] == i)) &&
               !(l_we && l_inc && s_port == i) && lcnt[i] != 11'h000)
        lcnt[i] <= lcnt[i] - 11'h001;
    end
  end
end

// ---------------------------------------------------------------
// apb registers
// ---------------------------------------------------------------
wire pg = PADDR[11:8] == `L2LA_PORT_PAGE;
wire [4:0] pi = PADDR[6:2];
wire p_hit = pg && PADDR[7] == 1'b0 && PADDR[1:0] == 2'h0 && pi < NPORT;
wire mapped = p_hit || PADDR == `L2LA_ADR_CTRL || PADDR == `L2LA_ADR_AGE ||
  PADDR == `L2LA_ADR_STAT || PADDR == `L2LA_ADR_OVF_LO || PADDR == `L2LA_ADR_OVF_HI ||
  PADDR == `L2LA_ADR_CFL_LO || PADDR == `L2LA_ADR_CFL_HI;
wire wr = PSEL && PENABLE && PWRITE && mapped;
assign PREADY = 1'b1;
assign PSLVERR = PSEL && PENABLE && !mapped;

always @(posedge REF_CLK or posedge RST) begin
  if (RST) begin
    ctrl <= `L2LA_CTRL_RST;
    tick_sel <= 3'h0;
    age_cfg <= AGE_TICKS_RST;
    p_en <= {NPORT{1'b1}};
    p_grp <= {NPORT{1'b0}};
    p_stat <= {NPORT{1'b0}};
    p_move <= {NPORT{1'b0}};
    for (i = 0; i < NPORT; i = i + 1)
      pmax[i] <= `L2LA_MAX_RST;
    ovf_key <= 57'h0;
    ovf_port <= 5'h00;
    cfl_key <= 57'h0;
    cfl_port <= 5'h00;
    PRDATA <= 32'h00000000;
  end else begin
    if (ovf) begin
      ovf_key <= s_key;
      ovf_port <= s_port;
    end
    if (cfl) begin
      cfl_key <= s_key;
      cfl_port <= s_port;
    end
    if (wr && PADDR == `L2LA_ADR_CTRL)
      ctrl <= PWDATA[4:0];
    if (wr && PADDR == `L2LA_ADR_AGE) begin
      tick_sel <= PWDATA[2:0];
      age_cfg <= PWDATA[23:8];
    end
    if (wr && p_hit) begin
      p_en[pi] <= PWDATA[`L2LA_P_EN];
      p_grp[pi] <= PWDATA[`L2LA_P_GRP];
      p_stat[pi] <= PWDATA[`L2LA_P_STAT];
      p_move[pi] <= PWDATA[`L2LA_P_MOVE];
      pmax[pi] <= PWDATA[`L2LA_P_MAX_LO+10:`L2LA_P_MAX_LO];
    end
    // read data is caught in the setup cycle, so no wait state is needed
    if (PSEL && !PENABLE) begin
      PRDATA <= 32'h00000000;
      if (p_hit)
        PRDATA <= {1'b0, lcnt[pi], 1'b0, pmax[pi], 4'h0,
                   p_move[pi], p_stat[pi], p_grp[pi], p_en[pi]};
      else if (PADDR == `L2LA_ADR_CTRL)
        PRDATA <= {27'h0, ctrl};
      else if (PADDR == `L2LA_ADR_AGE)
        PRDATA <= {8'h00, age_cfg, 5'h00, tick_sel};
      else if (PADDR == `L2LA_ADR_STAT)
        PRDATA <= {30'h0, hq_full, scan};
      else if (PADDR == `L2LA_ADR_OVF_LO)
        PRDATA <= ovf_key[31:0];
      else if (PADDR == `L2LA_ADR_OVF_HI)
        PRDATA <= {2'h0, ovf_port, ovf_key[56:32]};
      else if (PADDR == `L2LA_ADR_CFL_LO)
        PRDATA <= cfl_key[31:0];
      else if (PADDR == `L2LA_ADR_CFL_HI)
        PRDATA <= {2'h0, cfl_port, cfl_key[56:32]};
    end
  end
end

endmodule

// >>> shared/l2la_map.vh
// constants for the l2 learning and aging engine
// Notes on behaviour
// - each entry keeps valid, static and hit; hardware changes static entries only on a port move the move option allows
// - every status write copies valid to both shadow tables in the same cycle
// - 4 buckets of 256 read at the hash; collision search takes lowest index
// - bucket hit gives {bucket,hash}; collision hit gives index plus 1024
// - every packet that passes the learning filters is checked; a known non-static entry with hit 0 gets hit set
// - new entries are refused once the port's learned count reaches its maximum
// - allocation takes a free bucket first, then a free collision entry
// - no free entry and lru 0: overwrite non-static collision entries round robin
// - lru 1: last bucket with hit 0 static 0, else first such collision entry
// - else last non-static bucket, else non-static collision entry round robin
// - failed allocation or full port drops a new address and logs it as overflow
// - port moves relink non-static entries; static per move option; failures logged
// - learning decisions take the writeback bus ahead of everything else
// - no learning from cpu port when barred, from-cpu tag, or port disabled
// - no learning for to-cpu reason, forced destination, or acl skip flag
// - ingress drops block learning unless caused by spanning tree learning state
// - group source addresses except broadcast are learned only when port allows
// - learned entries start hit and valid, static from the port setting
// - aging scans every hash and collision entry after a set number of ticks
// - scan turns 101 into 001 and 001 into 000; others unchanged
// - new tick count waits for period end unless aging restarts; select is live
// - destination hits on valid non-static entries queue a hit update; full drops
// - source lookup classifies new address, port move or hit update
// - learning and aging are enabled after reset and can be switched off
`ifndef L2LA_MAP_VH
`define L2LA_MAP_VH
`define L2LA_KW 57
`define L2LA_AW 11
`define L2LA_PW 5
`define L2LA_NBKT 4
`define L2LA_NCOLL 16
`define L2LA_NENT 1040
`define L2LA_LAST 11'h40F
`define L2LA_COLL_BASE 11'h400
`define L2LA_GRP_BIT 40
`define L2LA_BCAST 48'hFFFFFFFFFFFF
`define L2LA_S_VALID 0
`define L2LA_S_STAT 1
`define L2LA_S_HIT 2
`define L2LA_ST_HV 3'h5
`define L2LA_ST_V 3'h1
`define L2LA_ST_NONE 3'h0
`define L2LA_WB_LEARN 2'h1
`define L2LA_WB_AGE 2'h2
`define L2LA_WB_HIT 2'h3
`define L2LA_ADR_CTRL 12'h000
`define L2LA_ADR_AGE 12'h004
`define L2LA_ADR_STAT 12'h008
`define L2LA_ADR_OVF_LO 12'h010
`define L2LA_ADR_OVF_HI 12'h014
`define L2LA_ADR_CFL_LO 12'h018
`define L2LA_ADR_CFL_HI 12'h01C
`define L2LA_PORT_PAGE 4'h1
`define L2LA_C_LEARN 0
`define L2LA_C_AGE 1
`define L2LA_C_LRU 2
`define L2LA_C_DHIT 3
`define L2LA_C_CPU 4
`define L2LA_CTRL_RST 5'h0B
`define L2LA_P_EN 0
`define L2LA_P_GRP 1
`define L2LA_P_STAT 2
`define L2LA_P_MOVE 3
`define L2LA_P_MAX_LO 8
`define L2LA_P_CNT_LO 20
`define L2LA_MAX_RST 11'h410
`endif

// >>> verification/l2la_shadow_model.sv
// ingress pipeline shadow valid tables, fed by the engine
`timescale 1ns/10ps
module l2la_shadow_model (
  // clock
  input wire clk,
  // shadow write port
  input wire we,
  input wire [10:0] addr,
  input wire sa_valid,
  input wire da_valid,
  // lookup
  input wire [10:0] q_addr,
  output wire q_valid,
  output reg split
);
  // ----
  // tables
  // ----
  reg sa_tab [0:1039];
  reg da_tab [0:1039];
  initial split = 1'b0;
  always @(posedge clk) begin
    if (we) begin
      sa_tab[addr] <= sa_valid;
      da_tab[addr] <= da_valid;
      // copies that differ would misroute source against destination
      if (sa_valid !== da_valid) split <= 1'b1;
    end
  end
  assign q_valid = sa_tab[q_addr] & da_tab[q_addr];
endmodule

// >>> verification/l2la_engine_asserts.sv
// port checker for the l2 learning and aging engine
`timescale 1ns/10ps
`include "l2la_map.vh"
module l2la_engine_asserts (
  // clock and reset
  input wire REF_CLK,
  input wire RST,
  // requests
  input wire LRN_VALID,
  input wire LRN_FROM_CPU,
  input wire DA_VALID,
  // results
  input wire DA_HIT,
  input wire [10:0] DA_ADDR,
  input wire WB_VALID,
  input wire [1:0] WB_KIND,
  input wire [10:0] WB_ADDR,
  input wire [2:0] WB_STATUS,
  input wire SHADOW_WE,
  input wire [10:0] SHADOW_ADDR,
  input wire SHADOW_SA_VALID,
  input wire SHADOW_DA_VALID
);
  // ----
  // properties
  // ----
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence learn_wr_s;
    WB_VALID && WB_KIND == `L2LA_WB_LEARN;
  endsequence
  sequence cpu_req_s;
    LRN_VALID && LRN_FROM_CPU;
  endsequence
  shadow_copy_a: assert property (WB_VALID |-> SHADOW_WE && SHADOW_ADDR == WB_ADDR &&
    SHADOW_SA_VALID == WB_STATUS[0] && SHADOW_DA_VALID == WB_STATUS[0])
    else $error("shadow copy differs from status write");
  shadow_only_a: assert property (SHADOW_WE |-> WB_VALID)
    else $error("shadow written without status write");
  learn_cause_a: assert property (learn_wr_s |-> $past(LRN_VALID, 2))
    else $error("learn write without request two cycles back");
  learn_status_a: assert property (learn_wr_s |-> WB_STATUS[0] && WB_STATUS[2])
    else $error("learned entry not hit and valid");
  cpu_skip_a: assert property (cpu_req_s |-> ##2 !(WB_VALID && WB_KIND == 2'h1))
    else $error("tagged cpu packet was learned");
  age_step_a: assert property (WB_VALID && WB_KIND == `L2LA_WB_AGE |->
    WB_STATUS == `L2LA_ST_V || WB_STATUS == `L2LA_ST_NONE)
    else $error("aging wrote an illegal status");
  hit_update_a: assert property (WB_VALID && WB_KIND == `L2LA_WB_HIT |-> WB_STATUS == 3'h5)
    else $error("hit update status wrong");
  da_cause_a: assert property (DA_HIT |-> $past(DA_VALID))
    else $error("lookup hit without lookup");
  coll_addr_a: assert property (DA_HIT && DA_ADDR[10] |-> DA_ADDR[9:4] == 6'h00)
    else $error("collision address out of range");
endmodule
bind l2la_engine l2la_engine_asserts i_l2la_engine_asserts (
  .REF_CLK(REF_CLK), .RST(RST), .LRN_VALID(LRN_VALID), .LRN_FROM_CPU(LRN_FROM_CPU),
  .DA_VALID(DA_VALID), .DA_HIT(DA_HIT), .DA_ADDR(DA_ADDR), .WB_VALID(WB_VALID),
  .WB_KIND(WB_KIND), .WB_ADDR(WB_ADDR), .WB_STATUS(WB_STATUS), .SHADOW_WE(SHADOW_WE),
  .SHADOW_ADDR(SHADOW_ADDR), .SHADOW_SA_VALID(SHADOW_SA_VALID),
  .SHADOW_DA_VALID(SHADOW_DA_VALID)
);

// >>> verification/l2la_engine_test.sv
// self-checking bench for the l2 learning and aging engine
`timescale 1ns/10ps
`include "l2la_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module l2la_engine_test;
  // ----
  // signals
  // ----
  reg REF_CLK, RST, PSEL, PENABLE, PWRITE, LRN_VALID, DA_VALID, tick_on;
  reg [11:0] PADDR;
  reg [31:0] PWDATA;
  reg [4:0] TICK, LRN_PORT;
  reg [47:0] LRN_MAC, DA_MAC;
  reg [8:0] LRN_GID, DA_GID;
  reg [7:0] LRN_HASH, DA_HASH;
  reg [5:0] flg;
  reg [10:0] q_addr;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, DA_HIT, WB_VALID, SHADOW_WE, sh_sa, sh_da, sh_q, split;
  wire [10:0] DA_ADDR, WB_ADDR, SHADOW_ADDR;
  wire [4:0] DA_PORT, WB_PORT;
  wire [1:0] WB_KIND;
  wire [56:0] WB_KEY;
  wire [2:0] WB_STATUS;
  reg [20:0] wb_q[$];
  int miscompares, compares, age01, age00, cycles, i;
  logic [31:0] rd;
  logic err;
  // short aging period keeps two full scans inside the run
  l2la_engine #(.AGE_TICKS_RST(16'h0002)) i_l2la_engine (.REF_CLK(REF_CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TICK(TICK),
    .LRN_VALID(LRN_VALID), .LRN_MAC(LRN_MAC), .LRN_GID(LRN_GID), .LRN_HASH(LRN_HASH),
    .LRN_PORT(LRN_PORT), .LRN_FROM_CPU(flg[5]), .LRN_TO_CPU_CODE(flg[4]),
    .LRN_FORCE_DEST(flg[3]), .LRN_ACL_SKIP(flg[2]), .LRN_DROP(flg[1]),
    .LRN_DROP_STP_LEARNING(flg[0]), .DA_VALID(DA_VALID), .DA_MAC(DA_MAC),
    .DA_GID(DA_GID), .DA_HASH(DA_HASH), .DA_HIT(DA_HIT), .DA_ADDR(DA_ADDR),
    .DA_PORT(DA_PORT), .WB_VALID(WB_VALID), .WB_KIND(WB_KIND), .WB_ADDR(WB_ADDR),
    .WB_KEY(WB_KEY), .WB_PORT(WB_PORT), .WB_STATUS(WB_STATUS), .SHADOW_WE(SHADOW_WE),
    .SHADOW_ADDR(SHADOW_ADDR), .SHADOW_SA_VALID(sh_sa), .SHADOW_DA_VALID(sh_da));
  l2la_shadow_model i_l2la_shadow_model (.clk(REF_CLK), .we(SHADOW_WE), .addr(SHADOW_ADDR),
    .sa_valid(sh_sa), .da_valid(sh_da), .q_addr(q_addr), .q_valid(sh_q), .split(split));
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  // ----
  // monitor, ticks and timeout
  // ----
  always @(posedge REF_CLK) begin
    cycles++;
    TICK <= (tick_on && cycles % 4 == 0) ? 5'h01 : 5'h00;
    if (WB_VALID === 1'b1) begin
      if (WB_KIND === `L2LA_WB_AGE) begin
        if (WB_STATUS === `L2LA_ST_V) age01++;
        else age00++;
      end else begin
        wb_q.push_back({WB_KIND, WB_ADDR, WB_PORT, WB_STATUS});
        if (WB_KIND === `L2LA_WB_LEARN) `CHK(WB_KEY, {9'h005, LRN_MAC})
      end
    end
    if (cycles == 20000) begin
      miscompares++;
      final_report;
    end
  end
  // ----
  // tasks
  // ----
  function automatic [47:0] mac(input int n);
    mac = 48'h020000000000 + n;
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1) @(posedge REF_CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task learn(input logic [47:0] m, input logic [7:0] h, input logic [4:0] p, input logic [5:0] f);
    LRN_VALID <= 1'b1; LRN_MAC <= m; LRN_GID <= 9'h005; LRN_HASH <= h; LRN_PORT <= p; flg <= f;
    @(posedge REF_CLK);
    LRN_VALID <= 1'b0;
    flg <= 6'h00;
    @(posedge REF_CLK);
  endtask
  task look(input logic [47:0] m, input logic [7:0] h, input logic [10:0] a, input logic [4:0] p);
    DA_VALID <= 1'b1; DA_MAC <= m; DA_GID <= 9'h005; DA_HASH <= h;
    @(posedge REF_CLK);
    DA_VALID <= 1'b0;
    #1;
    `CHK(DA_HIT, 1'b1)
    `CHK(DA_ADDR, a)
    `CHK(DA_PORT, p)
    @(posedge REF_CLK);
  endtask
  task expect_wb(input logic [1:0] k, input logic [10:0] a, input logic [4:0] p, input logic [2:0] s);
    logic [20:0] v;
    int n;
    n = 0;
    while (wb_q.size() == 0 && n < 10) begin
      @(posedge REF_CLK);
      n++;
    end
    `CHK(wb_q.size() > 0, 1'b1)
    v = (wb_q.size() > 0) ? wb_q.pop_front() : 21'h0;
    `CHK(v[20:8], {k, a})
    `CHK(v[2:0], s)
    if (k == `L2LA_WB_LEARN) `CHK(v[7:3], p)
  endtask
  task expect_none;
    repeat (5) @(posedge REF_CLK);
    `CHK(wb_q.size(), 0)
  endtask
  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    RST = 1'b1; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 12'h000; PWDATA = 32'h0;
    LRN_VALID = 1'b0; LRN_MAC = 48'h0; LRN_GID = 9'h000; LRN_HASH = 8'h00;
    LRN_PORT = 5'h00; flg = 6'h00; DA_VALID = 1'b0; DA_MAC = 48'h0; DA_GID = 9'h000;
    DA_HASH = 8'h00; tick_on = 1'b0; q_addr = 11'h000;
    repeat (20) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    rd_chk(`L2LA_ADR_CTRL, 32'h0000000B);
    rd_chk(`L2LA_ADR_AGE, 32'h00000200);
    rd_chk(12'h104, 32'h00041001);
    rd_chk(`L2LA_ADR_STAT, 32'h00000000);
    apb(1'b0, 12'h0F0, 32'h0);
    `CHK(err, 1'b1)
    $display("test reset values done");
    for (i = 0; i < 5; i++) begin
      learn(mac(i), 8'h10, 5'h01, 6'h00);
      expect_wb(2'h1, (i < 4) ? {1'b0, i[1:0], 8'h10} : `L2LA_COLL_BASE, 5'h01, 3'h5);
    end
    q_addr = 11'h010;
    #1;
    `CHK(sh_q, 1'b1)
    `CHK(split, 1'b0)
    look(mac(0), 8'h10, 11'h010, 5'h01);
    expect_wb(2'h3, 11'h010, 5'h00, 3'h5);
    look(mac(4), 8'h10, 11'h400, 5'h01);
    expect_wb(2'h3, 11'h400, 5'h00, 3'h5);
    learn(mac(0), 8'h10, 5'h04, 6'h00);
    expect_wb(2'h1, 11'h010, 5'h04, 3'h5);
    $display("test allocation and lookup done");
    for (i = 0; i < 5; i++) begin
      learn(mac(16 + i), 8'h20 + i, 5'h01, 6'h20 >> i);
      expect_none;
    end
    learn(mac(21), 8'h30, 5'h01, 6'h03);
    expect_wb(2'h1, 11'h030, 5'h01, 3'h5);
    learn(48'h030000000001, 8'h31, 5'h01, 6'h00);
    expect_none;
    apb(1'b1, `L2LA_ADR_CTRL, 32'h0000001B);
    learn(mac(22), 8'h32, 5'h00, 6'h00);
    expect_none;
    apb(1'b1, `L2LA_ADR_CTRL, 32'h0000000B);
    $display("test exceptions done");
    apb(1'b1, 12'h108, 32'h00000101);
    learn(mac(23), 8'h40, 5'h02, 6'h00);
    expect_wb(2'h1, 11'h040, 5'h02, 3'h5);
    learn(mac(24), 8'h41, 5'h02, 6'h00);
    expect_none;
    rd_chk(`L2LA_ADR_OVF_LO, 32'h00000018);
    apb(1'b1, 12'h114, 32'h00041005);
    learn(mac(30), 8'h50, 5'h05, 6'h00);
    expect_wb(2'h1, 11'h050, 5'h05, 3'h7);
    learn(mac(30), 8'h50, 5'h06, 6'h00);
    expect_none;
    rd_chk(`L2LA_ADR_CFL_LO, 32'h0000001E);
    rd_chk(`L2LA_ADR_CFL_HI, 32'h0C050200);
    $display("test port limit done");
    tick_on <= 1'b1;
    repeat (3000) @(posedge REF_CLK);
    tick_on <= 1'b0;
    `CHK(age01, 7)
    `CHK(age00, 7)
    #1;
    `CHK(sh_q, 1'b0)
    $display("test aging done");
    apb(1'b1, `L2LA_ADR_CTRL, 32'h00000009);
    for (i = 0; i < 20; i++) begin
      learn(mac(40 + i), 8'h60, 5'h03, 6'h00);
      expect_wb(2'h1, (i < 4) ? {1'b0, i[1:0], 8'h60} : 11'h3FC + i, 5'h03, 3'h5);
    end
    learn(mac(60), 8'h60, 5'h03, 6'h00);
    expect_wb(2'h1, 11'h400, 5'h03, 3'h5);
    learn(mac(61), 8'h60, 5'h03, 6'h00);
    expect_wb(2'h1, 11'h401, 5'h03, 3'h5);
    apb(1'b1, `L2LA_ADR_CTRL, 32'h0000000D);
    learn(mac(62), 8'h60, 5'h03, 6'h00);
    expect_wb(2'h1, 11'h360, 5'h03, 3'h5);
    rd_chk(12'h10C, 32'h01441001);
    // one scan clears the hit bit of every non-static entry, so lru picks buckets again
    apb(1'b1, `L2LA_ADR_CTRL, 32'h0000000F);
    tick_on <= 1'b1;
    repeat (1100) @(posedge REF_CLK);
    apb(1'b1, `L2LA_ADR_CTRL, 32'h0000000D);
    learn(mac(63), 8'h60, 5'h03, 6'h00);
    expect_wb(2'h1, 11'h360, 5'h03, 3'h5);
    learn(mac(64), 8'h60, 5'h03, 6'h00);
    expect_wb(2'h1, 11'h260, 5'h03, 3'h5);
    $display("test replacement done");
    final_report;
  end
endmodule
